// file: src/gdm_pkg.sv
// Shared constants and types for the gate driver diagnostics and mode control
package gdm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real NS_PER_MS     = 1.0E6;
  localparam real NS_PER_US     = 1.0E3;
  // Offline short test duration per selector code
  localparam real DIAG_DLY0_MS  = 0.25;
  localparam real DIAG_DLY1_MS  = 1.25;
  localparam real DIAG_DLY2_MS  = 5.0;
  localparam real DIAG_DLY3_MS  = 11.5;
  // Fixed duration of the pin-configured variant
  localparam real HW_DIAG_MS    = 2.0;
  // Enable low time that still counts as a fault reset pulse
  localparam real RST_WIN_US    = 40.0;
  // Enable low time before sleep is entered
  localparam real SLEEP_DLY_US  = 100.0;
  // Consecutive failing PWM pulses before active open load is reported
  localparam int  OLA_FAIL_CNT  = 3;
  localparam int  PHASES        = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PHASE  = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;

  // Status register fields
  localparam int ST_SUMMARY  = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_DIAG_LSB = 3;
  localparam int ST_UVLO     = 5;
  localparam int ST_FAULT    = 7;
  // Phase diagnostic register fields, one bit per phase
  localparam int PH_GND_LSB  = 0;
  localparam int PH_SUP_LSB  = 4;
  localparam int PH_OL_LSB   = 8;
  localparam int PH_VDSL_LSB = 12;
  localparam int PH_VDSH_LSB = 16;
  // Control register fields
  localparam int CT_CLR      = 0;
  localparam int CT_SHT      = 1;
  localparam int CT_DSEL_LSB = 2;
  localparam int CT_OLA_LSB  = 4;

  // Reset values
  localparam logic [1:0]  DSEL_RST = 2'h0;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  // AHB-Lite
  localparam int         HTRANS_ACT = 1;
  localparam logic       HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_OPER  = 2'b01,
    MODE_FAULT = 2'b11
  } gdm_mode_t;

  typedef enum logic [1:0] {
    DIAG_IDLE   = 2'b00,
    DIAG_SUPPLY = 2'b01,
    DIAG_GROUND = 2'b11
  } gdm_diag_t;

endpackage

// file: src/gdm_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module gdm_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // gdm_sync

// file: src/gdm_ctrl.sv
// Gate driver diagnostics and operating mode control with AHB-Lite registers
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module gdm_ctrl #(
  parameter bit          HW_VARIANT   = 1'b0,
  parameter int          CNT_W        = 24,
  parameter int unsigned DLY0_CYC     = $rtoi(gdm_pkg::DIAG_DLY0_MS * gdm_pkg::NS_PER_MS
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned DLY1_CYC     = $rtoi(gdm_pkg::DIAG_DLY1_MS * gdm_pkg::NS_PER_MS
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned DLY2_CYC     = $rtoi(gdm_pkg::DIAG_DLY2_MS * gdm_pkg::NS_PER_MS
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned DLY3_CYC     = $rtoi(gdm_pkg::DIAG_DLY3_MS * gdm_pkg::NS_PER_MS
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned HW_DLY_CYC   = $rtoi(gdm_pkg::HW_DIAG_MS * gdm_pkg::NS_PER_MS
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned RST_WIN_CYC  = $rtoi(gdm_pkg::RST_WIN_US * gdm_pkg::NS_PER_US
                                              / gdm_pkg::CLK_PERIOD_NS),
  parameter int unsigned SLEEP_CYC    = $rtoi(gdm_pkg::SLEEP_DLY_US * gdm_pkg::NS_PER_US
                                              / gdm_pkg::CLK_PERIOD_NS)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        enable_pin,
  input  wire logic        uvlo_in,
  input  wire logic        diag_select_pin_n,
  input  wire logic [2:0]  supply_cmp,
  input  wire logic [2:0]  ground_cmp,
  input  wire logic [2:0]  lowside_vds_cmp,
  input  wire logic [2:0]  highside_vds_cmp,
  input  wire logic [2:0]  pwm_end,
  input  wire logic [2:0]  open_load_ind,
  input  wire logic [2:0]  freewheel_seen,
  output logic             fault_out_n,
  output logic [2:0]       lowside_drain_pulldown_en,
  output logic [2:0]       phase_source_pullup_en,
  output logic             gate_drive_en,
  output logic             gate_pull_en,
  output logic             charge_pump_en,
  output logic             lowside_reg_en,
  output logic             digital_supply_en,
  output logic             serial_if_en
);

  localparam int NP = gdm_pkg::PHASES;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [14:0] pins_s;
  logic        en_s;
  logic        uvlo_s;
  logic        dsel_n_s;
  logic [2:0]  sup_s;
  logic [2:0]  gnd_s;
  logic [2:0]  vdsl_s;
  logic [2:0]  vdsh_s;

  gdm_sync #(.W(15)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({enable_pin, uvlo_in, diag_select_pin_n, supply_cmp, ground_cmp,
               lowside_vds_cmp, highside_vds_cmp}),
    .q       (pins_s)
  );

  assign {en_s, uvlo_s, dsel_n_s, sup_s, gnd_s, vdsl_s, vdsh_s} = pins_s;

  // ----------------------------------------------------------------
  // Shared state declarations
  // ----------------------------------------------------------------
  gdm_pkg::gdm_mode_t mode_r, mode_nxt;
  gdm_pkg::gdm_diag_t diag_r, diag_nxt;
  logic             en_q_r, en_q_nxt;
  logic [CNT_W-1:0] low_cnt_r, low_cnt_nxt;
  logic             hw_pend_r, hw_pend_nxt;
  logic [CNT_W-1:0] diag_cnt_r, diag_cnt_nxt;
  logic             sht_r, sht_nxt;
  logic [1:0]       dsel_r, dsel_nxt;
  logic [2:0]       ola_en_r, ola_en_nxt;
  logic [2:0]       gnd_f_r, gnd_f_nxt, sup_f_r, sup_f_nxt, ol_f_r, ol_f_nxt;
  logic [2:0]       vdsl_f_r, vdsl_f_nxt, vdsh_f_r, vdsh_f_nxt;
  logic [2:0]       ol_set;
  logic [7:0]       addr_r, addr_nxt;
  logic             wr_r, wr_nxt;
  logic             go_sleep, rst_pulse, wr_ctrl, clr_req, flags_nxt_any;
  logic [CNT_W-1:0] dur_cyc;

  assign go_sleep  = !en_s && (low_cnt_r >= CNT_W'(SLEEP_CYC - 1));
  assign rst_pulse = en_s && !en_q_r && (mode_r != gdm_pkg::MODE_SLEEP)
                     && (low_cnt_r <= CNT_W'(RST_WIN_CYC));
  assign wr_ctrl   = wr_r && (addr_r == gdm_pkg::ADDR_CTRL)
                     && (mode_r != gdm_pkg::MODE_SLEEP);
  assign clr_req   = rst_pulse || (!HW_VARIANT && wr_ctrl && hwdata[gdm_pkg::CT_CLR]);

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  always_comb begin
    en_q_nxt    = en_s;
    low_cnt_nxt = low_cnt_r;
    hw_pend_nxt = hw_pend_r;
    mode_nxt    = mode_r;
    if (en_s) begin
      low_cnt_nxt = '0;
    end else if (low_cnt_r != {CNT_W{1'b1}}) begin
      low_cnt_nxt = low_cnt_r + CNT_W'(1);
    end
    unique case (mode_r)
      gdm_pkg::MODE_SLEEP: begin
        if (en_s) begin
          mode_nxt    = gdm_pkg::MODE_OPER;
          hw_pend_nxt = HW_VARIANT && !dsel_n_s;
        end
      end
      gdm_pkg::MODE_OPER, gdm_pkg::MODE_FAULT: begin
        if (go_sleep) begin
          mode_nxt    = gdm_pkg::MODE_SLEEP;
          hw_pend_nxt = 1'b0;
        end else begin
          mode_nxt = flags_nxt_any ? gdm_pkg::MODE_FAULT : gdm_pkg::MODE_OPER;
        end
      end
      default: mode_nxt = gdm_pkg::MODE_SLEEP;
    endcase
    if (diag_r != gdm_pkg::DIAG_IDLE) begin
      hw_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r    <= gdm_pkg::MODE_SLEEP;
      en_q_r    <= 1'b0;
      low_cnt_r <= '0;
      hw_pend_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      en_q_r    <= en_q_nxt;
      low_cnt_r <= low_cnt_nxt;
      hw_pend_r <= hw_pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Offline short diagnostics sequencer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (dsel_r)
      2'h0:    dur_cyc = CNT_W'(DLY0_CYC);
      2'h1:    dur_cyc = CNT_W'(DLY1_CYC);
      2'h2:    dur_cyc = CNT_W'(DLY2_CYC);
      2'h3:    dur_cyc = CNT_W'(DLY3_CYC);
    endcase
    if (HW_VARIANT) begin
      dur_cyc = CNT_W'(HW_DLY_CYC);
    end
  end

  always_comb begin
    diag_nxt     = diag_r;
    diag_cnt_nxt = diag_cnt_r;
    if (mode_r == gdm_pkg::MODE_SLEEP || (!HW_VARIANT && !sht_r)) begin
      diag_nxt     = gdm_pkg::DIAG_IDLE;
      diag_cnt_nxt = '0;
    end
    unique case (diag_r)
      gdm_pkg::DIAG_IDLE: begin
        if (mode_r != gdm_pkg::MODE_SLEEP && (hw_pend_r || (!HW_VARIANT && sht_r))) begin
          diag_nxt     = gdm_pkg::DIAG_SUPPLY;
          diag_cnt_nxt = '0;
        end
      end
      gdm_pkg::DIAG_SUPPLY: begin
        if (diag_nxt != gdm_pkg::DIAG_IDLE) begin
          diag_cnt_nxt = diag_cnt_r + CNT_W'(1);
          if (diag_cnt_r >= dur_cyc - CNT_W'(1)) begin
            diag_nxt     = gdm_pkg::DIAG_GROUND;
            diag_cnt_nxt = '0;
          end
        end
      end
      gdm_pkg::DIAG_GROUND: begin
        if (diag_nxt != gdm_pkg::DIAG_IDLE) begin
          diag_cnt_nxt = diag_cnt_r + CNT_W'(1);
          if (diag_cnt_r >= dur_cyc - CNT_W'(1)) begin
            diag_nxt     = gdm_pkg::DIAG_IDLE;
            diag_cnt_nxt = '0;
          end
        end
      end
      default: diag_nxt = gdm_pkg::DIAG_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_r     <= gdm_pkg::DIAG_IDLE;
      diag_cnt_r <= '0;
    end else begin
      diag_r     <= diag_nxt;
      diag_cnt_r <= diag_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Active open load failure counters, one per phase
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_ola
      logic [1:0] cnt_r, cnt_nxt;
      logic       armed, fail;
      assign armed = gate_drive_en && (HW_VARIANT ? !dsel_n_s : ola_en_r[gp]);
      assign fail  = open_load_ind[gp] && !freewheel_seen[gp];
      assign ol_set[gp] = armed && pwm_end[gp] && fail
                          && (cnt_r == 2'(gdm_pkg::OLA_FAIL_CNT - 1));
      always_comb begin
        cnt_nxt = cnt_r;
        if (!armed) begin
          cnt_nxt = '0;
        end else if (pwm_end[gp]) begin
          if (!fail) begin
            cnt_nxt = '0;
          end else if (cnt_r != 2'(gdm_pkg::OLA_FAIL_CNT - 1)) begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault flags and control register
  // ----------------------------------------------------------------
  always_comb begin
    logic clr;
    clr        = clr_req || mode_r == gdm_pkg::MODE_SLEEP;
    // A set in the same cycle as a clear wins
    sup_f_nxt  = (sup_f_r & {NP{!clr}})
                 | (sup_s & {NP{diag_r == gdm_pkg::DIAG_SUPPLY}});
    gnd_f_nxt  = (gnd_f_r & {NP{!clr}})
                 | (gnd_s & {NP{diag_r == gdm_pkg::DIAG_GROUND}});
    ol_f_nxt   = (ol_f_r & {NP{!clr}}) | ol_set;
    vdsl_f_nxt = (vdsl_f_r & {NP{!clr}}) | (vdsl_s & {NP{gate_drive_en}});
    vdsh_f_nxt = (vdsh_f_r & {NP{!clr}}) | (vdsh_s & {NP{gate_drive_en}});
    flags_nxt_any = |{sup_f_nxt, gnd_f_nxt, ol_f_nxt, vdsl_f_nxt, vdsh_f_nxt};
    sht_nxt    = sht_r;
    dsel_nxt   = dsel_r;
    ola_en_nxt = ola_en_r;
    if (wr_ctrl && !HW_VARIANT) begin
      sht_nxt    = hwdata[gdm_pkg::CT_SHT];
      dsel_nxt   = hwdata[gdm_pkg::CT_DSEL_LSB +: 2];
      ola_en_nxt = hwdata[gdm_pkg::CT_OLA_LSB +: NP];
    end else if (diag_r == gdm_pkg::DIAG_GROUND && diag_nxt == gdm_pkg::DIAG_IDLE) begin
      sht_nxt = 1'b0;
    end
    if (mode_r == gdm_pkg::MODE_SLEEP) begin
      sht_nxt    = 1'b0;
      dsel_nxt   = gdm_pkg::DSEL_RST;
      ola_en_nxt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_f_r  <= '0;
      gnd_f_r  <= '0;
      ol_f_r   <= '0;
      vdsl_f_r <= '0;
      vdsh_f_r <= '0;
      sht_r    <= 1'b0;
      dsel_r   <= gdm_pkg::DSEL_RST;
      ola_en_r <= '0;
    end else begin
      sup_f_r  <= sup_f_nxt;
      gnd_f_r  <= gnd_f_nxt;
      ol_f_r   <= ol_f_nxt;
      vdsl_f_r <= vdsl_f_nxt;
      vdsh_f_r <= vdsh_f_nxt;
      sht_r    <= sht_nxt;
      dsel_r   <= dsel_nxt;
      ola_en_r <= ola_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;

  always_comb begin
    logic take;
    take     = hsel && htrans[gdm_pkg::HTRANS_ACT] && hready;
    addr_nxt = take ? haddr[7:0] : addr_r;
    wr_nxt   = take && hwrite;
    rd_nxt   = gdm_pkg::RD_ZERO;
    // Reads return the value after any write finishing in this cycle
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        gdm_pkg::ADDR_STATUS: begin
          rd_nxt[gdm_pkg::ST_FAULT]          = flags_nxt_any;
          rd_nxt[gdm_pkg::ST_SUMMARY]        = |{sup_f_nxt, gnd_f_nxt, ol_f_nxt};
          rd_nxt[gdm_pkg::ST_MODE_LSB +: 2]  = mode_nxt;
          rd_nxt[gdm_pkg::ST_DIAG_LSB +: 2]  = diag_nxt;
          rd_nxt[gdm_pkg::ST_UVLO]           = uvlo_s;
        end
        gdm_pkg::ADDR_PHASE: begin
          rd_nxt[gdm_pkg::PH_GND_LSB +: NP]  = gnd_f_nxt;
          rd_nxt[gdm_pkg::PH_SUP_LSB +: NP]  = sup_f_nxt;
          rd_nxt[gdm_pkg::PH_OL_LSB +: NP]   = ol_f_nxt;
          rd_nxt[gdm_pkg::PH_VDSL_LSB +: NP] = vdsl_f_nxt;
          rd_nxt[gdm_pkg::PH_VDSH_LSB +: NP] = vdsh_f_nxt;
        end
        gdm_pkg::ADDR_CTRL: begin
          rd_nxt[gdm_pkg::CT_SHT]            = sht_nxt;
          rd_nxt[gdm_pkg::CT_DSEL_LSB +: 2]  = dsel_nxt;
          rd_nxt[gdm_pkg::CT_OLA_LSB +: NP]  = ola_en_nxt;
        end
        default: rd_nxt = gdm_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r    <= '0;
      wr_r      <= 1'b0;
      hrdata    <= gdm_pkg::RD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= gdm_pkg::HRESP_OKAY;
    end else begin
      addr_r    <= addr_nxt;
      wr_r      <= wr_nxt;
      hrdata    <= rd_nxt;
      hreadyout <= 1'b1;
      hresp     <= gdm_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin and supply outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_out_n               <= 1'b1;
      lowside_drain_pulldown_en <= '0;
      phase_source_pullup_en    <= '0;
      gate_drive_en             <= 1'b0;
      gate_pull_en              <= 1'b1;
      charge_pump_en            <= 1'b0;
      lowside_reg_en            <= 1'b0;
      digital_supply_en         <= 1'b0;
      serial_if_en              <= 1'b0;
    end else begin
      fault_out_n               <= !flags_nxt_any;
      lowside_drain_pulldown_en <= {NP{diag_nxt == gdm_pkg::DIAG_SUPPLY}};
      phase_source_pullup_en    <= {NP{diag_nxt == gdm_pkg::DIAG_GROUND}};
      gate_drive_en             <= mode_nxt == gdm_pkg::MODE_OPER && !uvlo_s
                                   && diag_nxt == gdm_pkg::DIAG_IDLE;
      gate_pull_en              <= mode_nxt == gdm_pkg::MODE_SLEEP || uvlo_s;
      charge_pump_en            <= mode_nxt != gdm_pkg::MODE_SLEEP;
      lowside_reg_en            <= mode_nxt != gdm_pkg::MODE_SLEEP;
      digital_supply_en         <= mode_nxt != gdm_pkg::MODE_SLEEP;
      serial_if_en              <= mode_nxt != gdm_pkg::MODE_SLEEP;
    end
  end

endmodule // gdm_ctrl

// file: verification/gdm_bridge_model.sv
// Bridge, phase sense and PWM feedback model facing the control block
`timescale 1ns/1ns
module gdm_bridge_model (
  input  wire logic       hclk,
  input  wire logic [2:0] lowside_drain_pulldown_en,
  input  wire logic [2:0] phase_source_pullup_en,
  input  wire logic       gate_drive_en,
  input  wire logic [2:0] sup_mask,
  input  wire logic [2:0] gnd_mask,
  output logic      [2:0] supply_cmp,
  output logic      [2:0] ground_cmp,
  output logic      [2:0] lowside_vds_cmp,
  output logic      [2:0] highside_vds_cmp,
  output logic      [2:0] pwm_end,
  output logic      [2:0] open_load_ind,
  output logic      [2:0] freewheel_seen
);
  // Shorted phases trip the sense comparator only while their source is on
  assign supply_cmp       = lowside_drain_pulldown_en & sup_mask;
  assign ground_cmp       = phase_source_pullup_en & gnd_mask;
  // Host enables the bridge; the shorted phase shows a drain-source fault
  assign lowside_vds_cmp  = gate_drive_en ? sup_mask : 3'h0;
  assign highside_vds_cmp = gate_drive_en ? gnd_mask : 3'h0;
  initial begin
    pwm_end        = 3'h0;
    open_load_ind  = 3'h0;
    freewheel_seen = 3'h0;
  end
  // One pulse end, then the indications scramble until the next pulse
  task automatic pulse(input logic [2:0] ph, input logic ol, input logic fw);
    @(posedge hclk);
    pwm_end        <= ph;
    open_load_ind  <= ol ? ph : 3'h0;
    freewheel_seen <= fw ? ph : 3'h0;
    @(posedge hclk);
    pwm_end        <= 3'h0;
    open_load_ind  <= ~open_load_ind;
    freewheel_seen <= ~freewheel_seen;
    repeat (3) @(posedge hclk);
  endtask
endmodule // gdm_bridge_model

// file: verification/gdm_ctrl_checker.sv
// Port-level assertions for the gate driver control block
`timescale 1ns/1ns
module gdm_ctrl_checker #(
  parameter int unsigned SLEEP_CYC = 10000
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       enable_pin,
  input wire logic [2:0] supply_cmp,
  input wire logic [2:0] ground_cmp,
  input wire logic       fault_out_n,
  input wire logic [2:0] lowside_drain_pulldown_en,
  input wire logic [2:0] phase_source_pullup_en,
  input wire logic       gate_drive_en,
  input wire logic       gate_pull_en,
  input wire logic       charge_pump_en,
  input wire logic       serial_if_en
);
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_cnt_nxt;
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles the enable pin has been low, saturating
  always_comb begin
    lo_cnt_nxt = lo_cnt_r;
    if (enable_pin) lo_cnt_nxt = 16'h0;
    else if (lo_cnt_r != 16'hFFFF) lo_cnt_nxt = lo_cnt_r + 16'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lo_cnt_r <= 16'h0;
    else lo_cnt_r <= lo_cnt_nxt;
  end
  sequence en_held_s;
    $rose(enable_pin) ##1 enable_pin [*6];
  endsequence
  sequence fault_held_s;
    !fault_out_n ##1 !fault_out_n;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fault_blocks_a: assert property (fault_held_s |-> !gate_drive_en)
    else $error("gate drive active during latched fault");
  sleep_off_a: assert property (!serial_if_en |-> gate_pull_en && !gate_drive_en
    && !charge_pump_en) else $error("supplies or drive on while asleep");
  sleep_delay_a: assert property ($fell(serial_if_en) |-> lo_cnt_r >= SLEEP_CYC)
    else $error("sleep entered before delay");
  wake_a: assert property (en_held_s |-> serial_if_en)
    else $error("no wake after enable high");
  pull_excl_a: assert property (!(|lowside_drain_pulldown_en && |phase_source_pullup_en))
    else $error("pulldown and pullup sources on together");
  sup_first_a: assert property ($rose(phase_source_pullup_en[0])
    |-> $past(lowside_drain_pulldown_en[0])) else $error("ground test not after supply");
  supply_flag_a: assert property (|(supply_cmp & lowside_drain_pulldown_en)
    |-> ##[1:6] !fault_out_n) else $error("supply short not reported");
  ground_flag_a: assert property (|(ground_cmp & phase_source_pullup_en)
    |-> ##[1:6] !fault_out_n) else $error("ground short not reported");
endmodule // gdm_ctrl_checker

// file: verification/gdm_ctrl_tb.sv
// Self-checking testbench for the gate driver control block
`timescale 1ns/1ns
module gdm_ctrl_tb;
  localparam logic [7:0]  A_ST = gdm_pkg::ADDR_STATUS;
  localparam logic [7:0]  A_PH = gdm_pkg::ADDR_PHASE;
  localparam logic [7:0]  A_CT = gdm_pkg::ADDR_CTRL;
  localparam int          DLY2 = 40;
  localparam logic [31:0] S_OP = 32'(gdm_pkg::MODE_OPER) << gdm_pkg::ST_MODE_LSB;
  localparam logic [31:0] S_FL = (32'(gdm_pkg::MODE_FAULT) << gdm_pkg::ST_MODE_LSB)
                                 | (32'h1 << gdm_pkg::ST_FAULT) | 32'h1;
  logic        hclk, hresetn, hsel, hwrite, enable_pin, uvlo_in;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  sup_mask, gnd_mask;
  wire  [2:0]  supply_cmp, ground_cmp, lowside_vds_cmp, highside_vds_cmp;
  wire  [2:0]  pwm_end, open_load_ind, freewheel_seen;
  wire  [2:0]  lowside_drain_pulldown_en, phase_source_pullup_en;
  wire         hreadyout, hresp, fault_out_n, gate_drive_en, gate_pull_en;
  wire         charge_pump_en, lowside_reg_en, digital_supply_en, serial_if_en;
  wire  [31:0] hrdata;
  logic [2:0]  hsize;
  wire         hready = hreadyout;
  logic        diag_select_pin_n;
  int          error_cnt, n_checks;
  gdm_ctrl #(.DLY0_CYC(20), .DLY1_CYC(30), .DLY2_CYC(DLY2), .DLY3_CYC(50),
             .HW_DLY_CYC(20), .RST_WIN_CYC(8), .SLEEP_CYC(32)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .enable_pin, .uvlo_in, .diag_select_pin_n, .supply_cmp, .ground_cmp,
    .lowside_vds_cmp, .highside_vds_cmp, .pwm_end, .open_load_ind, .freewheel_seen,
    .fault_out_n, .lowside_drain_pulldown_en, .phase_source_pullup_en, .gate_drive_en,
    .gate_pull_en, .charge_pump_en, .lowside_reg_en, .digital_supply_en, .serial_if_en);
  gdm_bridge_model u_br (.hclk, .lowside_drain_pulldown_en, .phase_source_pullup_en,
    .gate_drive_en, .sup_mask, .gnd_mask, .supply_cmp, .ground_cmp, .lowside_vds_cmp,
    .highside_vds_cmp, .pwm_end, .open_load_ind, .freewheel_seen);
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready again
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(q & m, e);
    chk(32'(hresp), 32'(gdm_pkg::HRESP_OKAY));
  endtask
  task automatic reset_pulse(input int lo);
    enable_pin <= 1'b0;
    repeat (lo) @(posedge hclk);
    enable_pin <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {enable_pin, uvlo_in, sup_mask, gnd_mask, hsize, diag_select_pin_n} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(A_ST, 32'h0);
    enable_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(A_ST, S_OP);
    rdc(8'h0C, 32'h0);
    wr(A_CT, 32'h10);
    repeat (2) u_br.pulse(3'h1, 1'b1, 1'b0);
    u_br.pulse(3'h1, 1'b1, 1'b1);
    repeat (2) u_br.pulse(3'h1, 1'b1, 1'b0);
    rdc(A_PH, 32'h0);
    u_br.pulse(3'h1, 1'b1, 1'b0);
    rdc(A_PH, 32'h100);
    rdc(A_ST, S_FL);
    wr(A_CT, 32'h11);
    rdc(A_PH, 32'h0);
    rdc(A_CT, 32'h10);
    wr(A_CT, 32'h1A);
    // Short appears once the drivers are off, so no drain-source flag yet
    sup_mask <= 3'h2;
    for (n = 0; n < 50 && lowside_drain_pulldown_en !== 3'h7; n++) @(posedge hclk);
    for (n = 0; n < 99 && lowside_drain_pulldown_en === 3'h7; n++) @(posedge hclk);
    chk(32'(n), 32'(DLY2));
    chk(32'(phase_source_pullup_en), 32'h7);
    for (n = 0; n < 99 && phase_source_pullup_en !== 3'h0; n++) @(posedge hclk);
    rdc(A_PH, 32'h20);
    rdc(A_CT, 32'h18);
    chk(32'(fault_out_n), 32'h0);
    wr(A_CT, 32'h19);
    repeat (6) @(posedge hclk);
    rdc(A_PH, 32'h2000);
    sup_mask <= 3'h0;
    gnd_mask <= 3'h4;
    wr(A_CT, 32'h12);
    for (n = 0; n < 99 && phase_source_pullup_en !== 3'h7; n++) @(posedge hclk);
    for (n = 0; n < 99 && phase_source_pullup_en !== 3'h0; n++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    rdc(A_PH, 32'h2004);
    reset_pulse(4);
    rdc(A_PH, 32'h40000);
    rdc(A_CT, 32'h10);
    gnd_mask <= 3'h0;
    reset_pulse(4);
    rdc(A_ST, S_OP);
    uvlo_in <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(32'(gate_pull_en), 32'h1);
    rdc(A_ST, 32'h20, 32'h20);
    uvlo_in <= 1'b0;
    enable_pin <= 1'b0;
    repeat (16) @(posedge hclk);
    chk(32'({charge_pump_en, lowside_reg_en, digital_supply_en}), 32'h7);
    repeat (24) @(posedge hclk);
    chk(32'({charge_pump_en, lowside_reg_en, digital_supply_en}), 32'h0);
    rdc(A_CT, 32'h0);
    enable_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(A_ST, S_OP);
    summarize();
  end
endmodule // gdm_ctrl_tb

bind gdm_ctrl gdm_ctrl_checker #(.SLEEP_CYC(SLEEP_CYC)) u_chk (.hclk, .hresetn, .enable_pin,
  .supply_cmp, .ground_cmp, .fault_out_n, .lowside_drain_pulldown_en,
  .phase_source_pullup_en, .gate_drive_en, .gate_pull_en, .charge_pump_en, .serial_if_en);
